// ### src/ims_cfg.svh
// register map, field positions, reset values and timing counts of the sideband block
`ifndef IMS_CFG_SVH
`define IMS_CFG_SVH
// byte offsets, decoded on haddr[7:0]
`define IMS_A_REDIST_ID 8'h00
`define IMS_A_TRANS_ID 8'h04
`define IMS_A_CHIP_NUM 8'h08
`define IMS_A_STRAP 8'h0C
`define IMS_A_ERR_STAT 8'h10
`define IMS_A_ERR_EN 8'h14
`define IMS_A_PERF_CTRL 8'h20
`define IMS_A_PERF_CAP 8'h24
`define IMS_A_PERF_OVF 8'h28
`define IMS_A_PERF_SNAP 8'h30
// group decodes on haddr[7:4]
`define IMS_G_ERRREC 4'h1
`define IMS_G_PERF_LO 4'h2
`define IMS_G_PERF_HI 4'h3
// field positions
`define IMS_B_FAULT 0
`define IMS_B_ERR 1
`define IMS_B_CNT_EN 0
`define IMS_B_OVF_IE 1
// reset values
`define IMS_RST_ERR_EN 2'h0
`define IMS_RST_PERF_CTRL 2'h0
// synchroniser depth and tie-off capture delay in clock cycles
`define IMS_SYNC_STAGES 2
`define IMS_STRAP_WAIT 2'h2
`endif

// ### src/ims_pkg.sv
// types shared by the sideband block
package ims_pkg;
    // sample handshake states
    typedef enum logic {
        IMS_HS_IDLE,
        IMS_HS_ACK
    } ims_hs_t;
    // bus data word
    typedef logic [31:0] ims_word_t;
endpackage

// ### src/ims_sync.sv
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps
module ims_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // asynchronous pins and their synchronised copy
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q; // first stage, read only by second stage
    logic [WIDTH-1:0] sync_q; // second stage

    // each bit is independent; multi-bit ids are static ties so skew is harmless
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

// ### src/ims_perfcnt.sv
// performance counters with snapshot, sticky overflow and level interrupt
`timescale 1ns/10ps
module ims_perfcnt #(
    parameter int NUM_CNT = 2,
    parameter int CNT_W = 32
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // control
    input wire logic [NUM_CNT-1:0] event_in,
    input wire logic count_en_in,
    input wire logic ovf_irq_en_in,
    input wire logic capture_in,
    input wire logic [NUM_CNT-1:0] ovf_clr_in,
    // state
    output logic [NUM_CNT*CNT_W-1:0] snap_out,
    output logic [NUM_CNT-1:0] ovf_out,
    output logic irq_out
);
    logic [NUM_CNT-1:0] ovf_d; // next sticky overflow
    logic irq_d; // next interrupt level
    logic irq_q; // interrupt level register

    // one counter, snapshot and overflow bit per channel
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
            logic [CNT_W-1:0] cnt_q; // live count
            logic [CNT_W-1:0] cnt_d;
            logic [CNT_W-1:0] snap_q; // captured count
            logic [CNT_W-1:0] snap_d;
            logic wrap; // counter rolls over this cycle
            logic ovf_q;
            logic ovf_nxt; // next sticky overflow of this channel only
            // next values
            always_comb begin
                wrap = count_en_in && event_in[gi] && (&cnt_q);
                cnt_d = cnt_q;
                if (count_en_in && event_in[gi]) begin
                    cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
                end
                // snapshot takes the value before this cycle's increment
                snap_d = capture_in ? cnt_q : snap_q;
                // set wins over a clear in the same cycle
                ovf_nxt = wrap | (ovf_q & ~ovf_clr_in[gi]);
            end
            always_ff @(posedge clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    cnt_q <= '0;
                    snap_q <= '0;
                    ovf_q <= 1'b0;
                end else begin
                    cnt_q <= cnt_d;
                    snap_q <= snap_d;
                    ovf_q <= ovf_nxt;
                end
            end
            assign snap_out[gi*CNT_W +: CNT_W] = snap_q;
            assign ovf_out[gi] = ovf_q;
            // one driver per bit keeps the shared vector out of the per-channel process
            assign ovf_d[gi] = ovf_nxt;
        end
    endgenerate

    // level held as long as an enabled overflow stays pending
    always_comb begin
        irq_d = ovf_irq_en_in && (|ovf_d);
    end
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end
    assign irq_out = irq_q;
endmodule

// ### src/ims_top.sv
// sideband logic: id read-back, fault/error/overflow outputs, sample handshake, access tie-offs
`timescale 1ns/10ps
`include "ims_cfg.svh"
module ims_top #(
    parameter bit MULTI_CHIP = 1'b0,
    parameter int CHIP_W = 4,
    parameter int NUM_CNT = 2,
    parameter int CNT_W = 32
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // ahb-lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic hnonsec_in,
    input wire logic hready_in,
    input wire ims_pkg::ims_word_t hwdata_in,
    output ims_pkg::ims_word_t hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // identity tie-offs
    input wire logic [CHIP_W-1:0] chip_number_in,
    input wire logic [15:0] cluster_iface_number_in,
    input wire logic [7:0] translation_service_number_in,
    // access tie-offs, taken from reset
    input wire logic errrec_nonsecure_allow_in,
    input wire logic perfcnt_nonsecure_allow_in,
    // internal events from the controller
    input wire logic fault_event_in,
    input wire logic err_event_in,
    input wire logic [NUM_CNT-1:0] perf_event_in,
    // interrupt outputs
    output logic fault_int_out,
    output logic err_int_out,
    output logic pmu_int_out,
    // cross trigger handshake
    input wire logic sample_req_in,
    output logic sample_ack_out
);
    import ims_pkg::*;

    localparam int SYNC_W = 27 + CHIP_W; // 16 + 8 + 3 single bits

    logic [SYNC_W-1:0] pins_s; // synchronised pins
    logic req_s; // synchronised sample request
    logic errrec_tie_s;
    logic perf_tie_s;
    logic [15:0] clid_s;
    logic [7:0] tsid_s;
    logic [CHIP_W-1:0] chip_s;

    // the sample request and every tie-off go through the two-stage synchroniser first
    ims_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .async_in({sample_req_in, errrec_nonsecure_allow_in, perfcnt_nonsecure_allow_in,
                   cluster_iface_number_in, translation_service_number_in, chip_number_in}),
        .sync_out(pins_s)
    );
    assign {req_s, errrec_tie_s, perf_tie_s, clid_s, tsid_s, chip_s} = pins_s;

    // bus state
    logic wr_pend_q, wr_pend_d; // write data phase pending
    logic [7:0] wr_addr_q, wr_addr_d; // write offset
    logic wr_ns_q, wr_ns_d; // write was nonsecure
    ims_word_t hrdata_q, hrdata_d; // read data for data phase
    logic addr_ok; // address phase taken this cycle
    logic err_ok_a; // read may see error-record group
    logic perf_ok_a; // read may see counter group
    logic err_ok_w; // pending write may touch error-record group
    logic perf_ok_w; // pending write may touch counter group
    logic [3:0] grp_a; // address-phase group
    // control and status
    logic [1:0] err_pend_q, err_pend_d; // sticky fault/error bits
    logic [1:0] err_en_q, err_en_d; // output enables
    logic [1:0] perf_ctrl_q, perf_ctrl_d; // count enable, overflow enable
    logic fault_int_q, fault_int_d;
    logic err_int_q, err_int_d;
    logic [1:0] err_clr; // w1c strobe for error status
    logic [NUM_CNT-1:0] ovf_clr; // w1c strobe for overflow status
    logic cap_sw; // software capture write
    logic cap_hw; // capture from handshake
    // handshake and tie-off capture
    ims_hs_t hs_q, hs_d;
    logic ack_q, ack_d;
    logic [1:0] strap_cnt_q, strap_cnt_d; // waits out the synchroniser
    logic strap_taken_q, strap_taken_d;
    logic errrec_allow_q, errrec_allow_d;
    logic perf_allow_q, perf_allow_d;
    // counter block
    logic [NUM_CNT*CNT_W-1:0] snap;
    logic [NUM_CNT-1:0] ovf;
    logic pmu_irq;

    // access tie-offs are caught once, after the synchroniser has settled past reset
    always_comb begin
        strap_cnt_d = strap_cnt_q;
        strap_taken_d = strap_taken_q;
        errrec_allow_d = errrec_allow_q;
        perf_allow_d = perf_allow_q;
        if (!strap_taken_q) begin
            if (strap_cnt_q == `IMS_STRAP_WAIT) begin
                strap_taken_d = 1'b1;
                errrec_allow_d = errrec_tie_s;
                perf_allow_d = perf_tie_s;
            end else begin
                strap_cnt_d = strap_cnt_q + 2'h1;
            end
        end
    end
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            strap_cnt_q <= 2'h0;
            strap_taken_q <= 1'b0;
            errrec_allow_q <= 1'b0;
            perf_allow_q <= 1'b0;
        end else begin
            strap_cnt_q <= strap_cnt_d;
            strap_taken_q <= strap_taken_d;
            errrec_allow_q <= errrec_allow_d;
            perf_allow_q <= perf_allow_d;
        end
    end

    // ahb decode: zero wait, read data registered into the data phase
    always_comb begin
        addr_ok = hsel_in && htrans_in[1] && hready_in;
        grp_a = haddr_in[7:4];
        // nonsecure access to a denied group reads zero and drops writes
        err_ok_a = !hnonsec_in || errrec_allow_q;
        perf_ok_a = !hnonsec_in || perf_allow_q;
        err_ok_w = !wr_ns_q || errrec_allow_q;
        perf_ok_w = !wr_ns_q || perf_allow_q;
        wr_pend_d = addr_ok && hwrite_in;
        wr_addr_d = addr_ok ? haddr_in[7:0] : wr_addr_q;
        wr_ns_d = addr_ok ? hnonsec_in : wr_ns_q;
        hrdata_d = 32'h0000_0000;
        if (addr_ok && !hwrite_in) begin
            case (haddr_in[7:0])
                `IMS_A_REDIST_ID: hrdata_d = {16'h0000, clid_s};
                `IMS_A_TRANS_ID: hrdata_d = {24'h00_0000, tsid_s};
                `IMS_A_CHIP_NUM: begin
                    // single-chip builds have no chip number and read zero
                    if (MULTI_CHIP) begin
                        hrdata_d[CHIP_W-1:0] = chip_s;
                    end
                end
                `IMS_A_STRAP: hrdata_d[2:0] = {strap_taken_q, perf_allow_q, errrec_allow_q};
                `IMS_A_ERR_STAT: hrdata_d[1:0] = err_ok_a ? err_pend_q : 2'h0;
                `IMS_A_ERR_EN: hrdata_d[1:0] = err_ok_a ? err_en_q : 2'h0;
                `IMS_A_PERF_CTRL: hrdata_d[1:0] = perf_ok_a ? perf_ctrl_q : 2'h0;
                `IMS_A_PERF_OVF: hrdata_d[NUM_CNT-1:0] = perf_ok_a ? ovf : '0;
                default: begin
                    // snapshot words; anything else unmapped reads zero
                    if (grp_a == `IMS_G_PERF_HI && int'(haddr_in[3:2]) < NUM_CNT && perf_ok_a) begin
                        // counters narrower than a word read with zero upper bits
                        hrdata_d[CNT_W-1:0] = snap[int'(haddr_in[3:2])*CNT_W +: CNT_W];
                    end
                end
            endcase
        end
    end
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_ns_q <= 1'b0;
            hrdata_q <= 32'h0000_0000;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            wr_ns_q <= wr_ns_d;
            hrdata_q <= hrdata_d;
        end
    end

    // register writes land in the data phase; status bits are write-one-to-clear
    always_comb begin
        err_en_d = err_en_q;
        perf_ctrl_d = perf_ctrl_q;
        err_clr = 2'h0;
        ovf_clr = '0;
        cap_sw = 1'b0;
        if (wr_pend_q) begin
            case (wr_addr_q)
                `IMS_A_ERR_STAT: err_clr = err_ok_w ? hwdata_in[1:0] : 2'h0;
                `IMS_A_ERR_EN: err_en_d = err_ok_w ? hwdata_in[1:0] : err_en_q;
                `IMS_A_PERF_CTRL: perf_ctrl_d = perf_ok_w ? hwdata_in[1:0] : perf_ctrl_q;
                `IMS_A_PERF_CAP: cap_sw = perf_ok_w;
                `IMS_A_PERF_OVF: ovf_clr = perf_ok_w ? hwdata_in[NUM_CNT-1:0] : '0;
                default: begin
                    // read-only or unmapped: write ignored
                end
            endcase
        end
        // a new event beats a clear in the same cycle
        err_pend_d = (err_pend_q & ~err_clr) | {err_event_in, fault_event_in};
        fault_int_d = err_pend_d[`IMS_B_FAULT] && err_en_d[`IMS_B_FAULT];
        err_int_d = err_pend_d[`IMS_B_ERR] && err_en_d[`IMS_B_ERR];
    end
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            err_en_q <= `IMS_RST_ERR_EN;
            perf_ctrl_q <= `IMS_RST_PERF_CTRL;
            err_pend_q <= 2'h0;
            fault_int_q <= 1'b0;
            err_int_q <= 1'b0;
        end else begin
            err_en_q <= err_en_d;
            perf_ctrl_q <= perf_ctrl_d;
            err_pend_q <= err_pend_d;
            fault_int_q <= fault_int_d;
            err_int_q <= err_int_d;
        end
    end

    // four-phase sample handshake; capture fires once per request
    always_comb begin
        hs_d = hs_q;
        cap_hw = 1'b0;
        case (hs_q)
            IMS_HS_IDLE: begin
                if (req_s) begin
                    cap_hw = 1'b1;
                    hs_d = IMS_HS_ACK;
                end
            end
            IMS_HS_ACK: begin
                // ack held until the request is seen low
                if (!req_s) begin
                    hs_d = IMS_HS_IDLE;
                end
            end
            default: hs_d = IMS_HS_IDLE;
        endcase
        ack_d = (hs_d == IMS_HS_ACK);
    end
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            hs_q <= IMS_HS_IDLE;
            ack_q <= 1'b0;
        end else begin
            hs_q <= hs_d;
            ack_q <= ack_d;
        end
    end

    // counters; hardware and software capture share one strobe
    ims_perfcnt #(
        .NUM_CNT(NUM_CNT),
        .CNT_W(CNT_W)
    ) u_perf (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .event_in(perf_event_in),
        .count_en_in(perf_ctrl_q[`IMS_B_CNT_EN]),
        .ovf_irq_en_in(perf_ctrl_d[`IMS_B_OVF_IE]),
        .capture_in(cap_sw | cap_hw),
        .ovf_clr_in(ovf_clr),
        .snap_out(snap),
        .ovf_out(ovf),
        .irq_out(pmu_irq)
    );

    // outputs straight from flip-flops; hreadyout and hresp are tied to constants
    assign hrdata_out = hrdata_q;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign fault_int_out = fault_int_q;
    assign err_int_out = err_int_q;
    assign pmu_int_out = pmu_irq;
    assign sample_ack_out = ack_q;

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    logic rd_a;
    assign rd_a = addr_ok && !hwrite_in;
    sequence s_req_taken;
        hs_q == IMS_HS_IDLE && req_s;
    endsequence
    a_redist_id_read: assert property (rd_a && haddr_in[7:0] == `IMS_A_REDIST_ID
        |=> hrdata_out == {16'h0000, $past(clid_s)}) else $error("redistributor id mismatch");
    a_trans_id_read: assert property (rd_a && haddr_in[7:0] == `IMS_A_TRANS_ID
        |=> hrdata_out == {24'h00_0000, $past(tsid_s)}) else $error("translation id mismatch");
    a_chip_absent: assert property (rd_a && haddr_in[7:0] == `IMS_A_CHIP_NUM && !MULTI_CHIP
        |=> hrdata_out == 32'h0000_0000) else $error("chip number visible in single-chip build");
    a_fault_out: assert property (fault_event_in && err_en_q[0] && !wr_pend_q
        |=> fault_int_out) else $error("fault output not raised");
    a_err_out: assert property (err_event_in && err_en_q[1] && !wr_pend_q
        |=> err_int_out) else $error("error output not raised");
    a_pmu_level: assert property (pmu_int_out && !wr_pend_q
        |=> pmu_int_out) else $error("overflow level dropped without a write");
    a_sample_capture: assert property (s_req_taken |-> cap_hw ##1 sample_ack_out)
        else $error("sample request not captured and acknowledged");
    a_ack_cause: assert property ($rose(sample_ack_out) |-> $past(req_s))
        else $error("acknowledge without request");
    a_ack_hold: assert property (sample_ack_out && req_s |=> sample_ack_out ##0 !cap_hw)
        else $error("acknowledge dropped while request held");
    a_ack_release: assert property (sample_ack_out && !req_s |=> !sample_ack_out)
        else $error("acknowledge not released");
    a_ns_errrec_block: assert property (rd_a && hnonsec_in && !errrec_allow_q
        && grp_a == `IMS_G_ERRREC |=> hrdata_out == 32'h0000_0000) else $error("nonsecure error-record leak");
    a_ns_perf_block: assert property (rd_a && hnonsec_in && !perf_allow_q
        && (grp_a == `IMS_G_PERF_LO || grp_a == `IMS_G_PERF_HI) |=> hrdata_out == 32'h0000_0000)
        else $error("nonsecure counter leak");
endmodule

// ### testbench/ims_cti_model.sv
// behavioural cross trigger unit driving the counter sample handshake
`timescale 1ns/10ps
module ims_cti_model (
    // clock
    input wire logic clk_in,
    // handshake with the sideband block
    input wire logic sample_ack_in,
    output logic sample_req_out
);
    // request idles low between handshakes
    initial sample_req_out = 1'b0;

    // one four-phase exchange; linger holds req past ack to model a slow partner
    task automatic sample(input int linger, output logic ok);
        int n;
        ok = 1'b1;
        @(posedge clk_in);
        sample_req_out <= 1'b1;
        n = 0;
        // hold req until ack is seen high, bounded so a dead ack cannot hang us
        do begin
            @(posedge clk_in);
            n++;
        end while (sample_ack_in !== 1'b1 && n < 20);
        if (n >= 20) ok = 1'b0;
        repeat (linger) @(posedge clk_in);
        sample_req_out <= 1'b0;
        n = 0;
        // no new request until ack has gone low again
        do begin
            @(posedge clk_in);
            n++;
        end while (sample_ack_in !== 1'b0 && n < 20);
        if (n >= 20) ok = 1'b0;
    endtask
endmodule

// ### testbench/intc_misc_sideband_tb_top.sv
// self-checking bench for the sideband block over its ahb-lite port
`timescale 1ns/10ps
`include "ims_cfg.svh"
module intc_misc_sideband_tb_top;
    import ims_pkg::*;
    // stream destination id of the translation service, tied to its number
    localparam logic [7:0] STREAM_DEST = 8'h3B;
    // bus and sideband stimulus
    logic clk_in, reset_n_in, hsel, hwrite, hnonsec, ns, fault_ev, err_ev, sample_req;
    // access tie-offs, swapped across the second reset
    logic errrec_tie, perf_tie;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [1:0] perf_ev;
    ims_word_t hwdata, hrdata, rd;
    // design outputs
    logic hready, hresp, fault_int, err_int, pmu_int, sample_ack, ok;
    // bookkeeping
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;

    // single-chip build, so the chip number must read as zero; 4-bit counters so a wrap is reachable
    ims_top #(.MULTI_CHIP(1'b0), .CHIP_W(4), .NUM_CNT(2), .CNT_W(4)) dut_u (
        .clk_in(clk_in), .reset_n_in(reset_n_in),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(hsize), .hnonsec_in(hnonsec), .hready_in(hready), .hwdata_in(hwdata),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .chip_number_in(4'h9), .cluster_iface_number_in(16'hA5C3),
        .translation_service_number_in(STREAM_DEST),
        .errrec_nonsecure_allow_in(errrec_tie), .perfcnt_nonsecure_allow_in(perf_tie),
        .fault_event_in(fault_ev), .err_event_in(err_ev), .perf_event_in(perf_ev),
        .fault_int_out(fault_int), .err_int_out(err_int), .pmu_int_out(pmu_int),
        .sample_req_in(sample_req), .sample_ack_out(sample_ack)
    );

    // far-side partner on the sample handshake
    ims_cti_model cti_u (.clk_in(clk_in), .sample_ack_in(sample_ack), .sample_req_out(sample_req));

    // 100 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // hang guard: the sequence needs well under a thousand cycles
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            complete_run();
        end
    end

    // verdict and end of run
    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // compare seen against expected, four-state exact
    task automatic check(input ims_word_t seen, input ims_word_t exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // one single word transfer; read data taken at the closing edge
    task automatic xfer(input logic wr, input logic [7:0] a, input ims_word_t wd, output ims_word_t q);
        @(posedge clk_in);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        hsize <= 3'b010;
        hnonsec <= ns;
        do @(posedge clk_in); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk_in); while (hready !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input ims_word_t d);
        xfer(1'b1, a, d, rd);
    endtask

    task automatic rd_chk(input logic [7:0] a, input ims_word_t exp);
        xfer(1'b0, a, 32'h0, rd);
        check(rd, exp);
    endtask

    // one-cycle internal event, then time for the level output to settle
    task automatic pulse(input logic f);
        @(posedge clk_in);
        if (f) fault_ev <= 1'b1;
        else err_ev <= 1'b1;
        @(posedge clk_in);
        fault_ev <= 1'b0;
        err_ev <= 1'b0;
        repeat (2) @(posedge clk_in);
    endtask

    // n increments of counter 0 only
    task automatic count(input int n);
        @(posedge clk_in);
        perf_ev <= 2'b01;
        repeat (n) @(posedge clk_in);
        perf_ev <= 2'b00;
    endtask

    // main sequence
    initial begin
        {hsel, hwrite, hnonsec, ns, fault_ev, err_ev, reset_n_in} = '0;
        errrec_tie = 1'b1;
        perf_tie = 1'b0;
        haddr = '0;
        htrans = '0;
        hsize = 3'b010;
        perf_ev = '0;
        hwdata = '0;
        repeat (2) @(posedge clk_in);
        check({hready, fault_int, err_int, pmu_int, sample_ack}, 32'h10);
        reset_n_in <= 1'b1;
        // tie-offs are taken a few edges after release
        repeat (4) @(posedge clk_in);
        rd_chk(`IMS_A_STRAP, 32'h5);
        rd_chk(`IMS_A_REDIST_ID, 32'hA5C3);
        wr(`IMS_A_REDIST_ID, 32'hFFFFFFFF);
        rd_chk(`IMS_A_REDIST_ID, 32'hA5C3);
        rd_chk(`IMS_A_TRANS_ID, {24'h0, STREAM_DEST});
        rd_chk(`IMS_A_CHIP_NUM, 32'h0);
        rd_chk(8'h40, 32'h0);
        // nonsecure: error group allowed, counter group denied
        ns = 1'b1;
        wr(`IMS_A_ERR_EN, 32'h3);
        rd_chk(`IMS_A_ERR_EN, 32'h3);
        wr(`IMS_A_PERF_CTRL, 32'h3);
        rd_chk(`IMS_A_PERF_CTRL, 32'h0);
        ns = 1'b0;
        rd_chk(`IMS_A_PERF_CTRL, 32'h0);
        // fault and error outputs, sticky until cleared
        pulse(1'b1);
        check({fault_int, err_int}, 32'h2);
        pulse(1'b0);
        check(err_int, 32'h1);
        rd_chk(`IMS_A_ERR_STAT, 32'h3);
        wr(`IMS_A_ERR_STAT, 32'h1);
        rd_chk(`IMS_A_ERR_STAT, 32'h2);
        check({fault_int, err_int}, 32'h1);
        wr(`IMS_A_ERR_EN, 32'h0);
        rd_chk(`IMS_A_ERR_STAT, 32'h2);
        check(err_int, 32'h0);
        // counters: software capture, then cross trigger samples slow and prompt
        wr(`IMS_A_PERF_CTRL, 32'h3);
        count(5);
        wr(`IMS_A_PERF_CAP, 32'h0);
        rd_chk(`IMS_A_PERF_SNAP, 32'h5);
        rd_chk(`IMS_A_PERF_SNAP + 8'h04, 32'h0);
        count(7);
        cti_u.sample(3, ok);
        check(ok, 32'h1);
        rd_chk(`IMS_A_PERF_SNAP, 32'hC);
        count(2);
        cti_u.sample(0, ok);
        check(ok, 32'h1);
        rd_chk(`IMS_A_PERF_SNAP, 32'hE);
        // no wrap reached, so no overflow level
        rd_chk(`IMS_A_PERF_OVF, 32'h0);
        check(pmu_int, 32'h0);
        // counter 0 wraps from 15 to 0: sticky overflow holds the level output
        count(2);
        repeat (2) @(posedge clk_in);
        rd_chk(`IMS_A_PERF_OVF, 32'h1);
        check(pmu_int, 32'h1);
        wr(`IMS_A_PERF_OVF, 32'h1);
        rd_chk(`IMS_A_PERF_OVF, 32'h0);
        check(pmu_int, 32'h0);
        // second reset with swapped tie-offs: error group denied, counter group allowed
        @(posedge clk_in);
        errrec_tie <= 1'b0;
        perf_tie <= 1'b1;
        reset_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        check({hready, fault_int, err_int, pmu_int, sample_ack}, 32'h10);
        reset_n_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        rd_chk(`IMS_A_STRAP, 32'h6);
        ns = 1'b1;
        wr(`IMS_A_ERR_EN, 32'h3);
        rd_chk(`IMS_A_ERR_EN, 32'h0);
        wr(`IMS_A_PERF_CTRL, 32'h1);
        rd_chk(`IMS_A_PERF_CTRL, 32'h1);
        ns = 1'b0;
        rd_chk(`IMS_A_ERR_EN, 32'h0);
        complete_run();
    end
endmodule
